// ==== pkg/ps2h_consts.vh ====
// constants of the two-port ps/2 host block
// assumes a single 125 MHz system clock feeding every counter
`ifndef PS2H_CONSTS_VH
`define PS2H_CONSTS_VH

`define PS2H_MCLK_NS      8
`define PS2H_HALF_NS      64
`define PS2H_HALF_CYC     ((`PS2H_HALF_NS + `PS2H_MCLK_NS - 1) / `PS2H_MCLK_NS)
`define PS2H_DIV_W        4
`define PS2H_SETTLE_CYC   4'h3
`define PS2H_FRAME_BITS   11
`define PS2H_LAST_BIT     4'hA
`define PS2H_BIT_W        4
`define PS2H_PKT_BYTES    2'h3

`define PS2H_MODE_IDLE    2'h0
`define PS2H_MODE_RX      2'h1
`define PS2H_MODE_TX      2'h2

`endif

// ==== rtl/ps2h_port.v ====
// two ps/2 host ports: port 0 keyboard (both directions), port 1 mouse (receive only)
// assumes open-drain pins resolved outside; pin inputs are asynchronous to mclk
//
// Overview of operation
// - Each word is 11 bits: start, eight data bits, odd parity, stop.
// - Clock and data are open-drain; data idles high, the host clock runs continuously; a party only releases or pulls low.
// - A zero is sent by pulling the line low, a one by releasing it.
// - Data is bidirectional, so the host data pin is a tri-state low-only driver.
// - Only the host pulls the clock low and so sets the link speed; the peripheral never does.
// - The keyboard port also transmits words from host to keyboard.
// - Received bytes are interpreted per port: keyboard bytes singly, mouse bytes as packets.
// - Two independent ports with identical clock and data timing are provided.
`include "ps2h_consts.vh"

module ps2h_port (
    input  wire        mclk,
    input  wire        rst_b,
    input  wire        keyboard_port_clock_in,
    output wire        keyboard_port_clock_out,
    output wire        keyboard_port_clock_oe,
    input  wire        keyboard_port_data_in,
    output wire        keyboard_port_data_out,
    output wire        keyboard_port_data_oe,
    input  wire        mouse_port_clock_in,
    output wire        mouse_port_clock_out,
    output wire        mouse_port_clock_oe,
    input  wire        mouse_port_data_in,
    output wire        mouse_port_data_out,
    output wire        mouse_port_data_oe,
    input  wire [7:0]  kbd_tx_byte,
    input  wire        kbd_tx_valid,
    output wire        kbd_tx_ready,
    output wire [7:0]  kbd_rx_byte,
    output wire        kbd_rx_valid,
    output wire        kbd_rx_err,
    output wire        kbd_clk_fault,
    output reg  [23:0] mouse_packet,
    output reg         mouse_packet_valid,
    output wire        mouse_rx_err,
    output wire        mouse_clk_fault
);

    localparam integer           HALF_LAST_I = `PS2H_HALF_CYC - 1;
    localparam [`PS2H_DIV_W-1:0] HALF_LAST   = HALF_LAST_I[`PS2H_DIV_W-1:0];

    reg        rst_meta_r;
    reg        rst_sync_r;
    wire       rst_n = rst_sync_r;

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    wire [1:0] clk_pin  = {mouse_port_clock_in, keyboard_port_clock_in};
    wire [1:0] data_pin = {mouse_port_data_in, keyboard_port_data_in};
    wire [1:0] clk_oe;
    wire [1:0] data_oe;
    wire [1:0] rx_vld;
    wire [1:0] rx_bad;
    wire [1:0] clk_bad;
    wire [15:0] rx_byte;
    wire [1:0] tx_rdy;

    // both ports come from one body, so their link timing is the same
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_port
            reg                    clk_meta_r, clk_s_r, dat_meta_r, dat_s_r;
            reg [`PS2H_DIV_W-1:0]  div_r;
            reg                    low_r;
            reg [1:0]              mode_r;
            reg [`PS2H_BIT_W-1:0]  bit_r;
            reg [9:0]              sh_r;
            reg                    dat_oe_r;
            reg                    vld_r, bad_r, cf_r;
            reg [7:0]              byte_r;
            wire                   tick = (div_r == HALF_LAST);
            wire                   fall = tick && !low_r;
            wire                   rise = tick && low_r;
            wire [`PS2H_FRAME_BITS-1:0] frame = {dat_s_r, sh_r};
            wire                   tx_go;

            // only port 0 may transmit
            if (i == 0) begin : g_tx
                assign tx_go = kbd_tx_valid && tx_rdy[0];
                assign tx_rdy[0] = (mode_r == `PS2H_MODE_IDLE) && fall && dat_s_r;
            end else begin : g_notx
                assign tx_go = 1'b0;
                assign tx_rdy[1] = 1'b0;
            end

            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    clk_meta_r <= 1'b1;
                    clk_s_r    <= 1'b1;
                    dat_meta_r <= 1'b1;
                    dat_s_r    <= 1'b1;
                end else begin
                    clk_meta_r <= clk_pin[i];
                    clk_s_r    <= clk_meta_r;
                    dat_meta_r <= data_pin[i];
                    dat_s_r    <= dat_meta_r;
                end
            end

            // host divider is the only source of link clock edges
            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    div_r <= {`PS2H_DIV_W{1'b0}};
                    low_r <= 1'b0;
                end else if (tick) begin
                    div_r <= {`PS2H_DIV_W{1'b0}};
                    low_r <= !low_r;
                end else begin
                    div_r <= div_r + 1'b1;
                end
            end

            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    mode_r   <= `PS2H_MODE_IDLE;
                    bit_r    <= {`PS2H_BIT_W{1'b0}};
                    sh_r     <= 10'h000;
                    dat_oe_r <= 1'b0;
                    vld_r    <= 1'b0;
                    bad_r    <= 1'b0;
                    byte_r   <= 8'h00;
                end else begin
                    vld_r <= 1'b0;
                    bad_r <= 1'b0;
                    case (mode_r)
                        `PS2H_MODE_IDLE: begin
                            if (tx_go) begin
                                // start bit goes out now, the rest shift one per fall
                                sh_r     <= {1'b1, ~^kbd_tx_byte, kbd_tx_byte};
                                dat_oe_r <= 1'b1;
                                bit_r    <= {`PS2H_BIT_W{1'b0}};
                                mode_r   <= `PS2H_MODE_TX;
                            end else if (rise && !dat_s_r) begin
                                sh_r   <= {dat_s_r, sh_r[9:1]};
                                bit_r  <= 4'h1;
                                mode_r <= `PS2H_MODE_RX;
                            end
                        end
                        `PS2H_MODE_RX: begin
                            if (rise) begin
                                if (bit_r == `PS2H_LAST_BIT) begin
                                    byte_r <= frame[8:1];
                                    vld_r  <= 1'b1;
                                    bad_r  <= frame[0] || !frame[10] || !(^frame[9:1]);
                                    mode_r <= `PS2H_MODE_IDLE;
                                end else begin
                                    sh_r  <= {dat_s_r, sh_r[9:1]};
                                    bit_r <= bit_r + 1'b1;
                                end
                            end
                        end
                        `PS2H_MODE_TX: begin
                            // stop bit is a release, so the last fall must still drive it
                            if (fall) begin
                                dat_oe_r <= ~sh_r[0];
                                sh_r     <= {1'b0, sh_r[9:1]};
                            end
                            if (rise) begin
                                if (bit_r == `PS2H_LAST_BIT) begin
                                    dat_oe_r <= 1'b0;
                                    mode_r   <= `PS2H_MODE_IDLE;
                                end else begin
                                    bit_r <= bit_r + 1'b1;
                                end
                            end
                        end
                        default: begin
                            mode_r   <= `PS2H_MODE_IDLE;
                            dat_oe_r <= 1'b0;
                        end
                    endcase
                end
            end

            // a low clock while we release it means the far end is pulling it
            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n)
                    cf_r <= 1'b0;
                else
                    cf_r <= !low_r && (div_r >= `PS2H_SETTLE_CYC) && !clk_s_r;
            end

            assign clk_oe[i]          = low_r;
            assign data_oe[i]         = dat_oe_r;
            assign rx_vld[i]          = vld_r;
            assign rx_bad[i]          = bad_r;
            assign clk_bad[i]         = cf_r;
            assign rx_byte[i*8 +: 8]  = byte_r;
        end
    endgenerate

    // outputs are only ever low: release means high via pull-up
    assign keyboard_port_clock_out = 1'b0;
    assign keyboard_port_clock_oe  = clk_oe[0];
    assign keyboard_port_data_out  = 1'b0;
    assign keyboard_port_data_oe   = data_oe[0];
    assign mouse_port_clock_out    = 1'b0;
    assign mouse_port_clock_oe     = clk_oe[1];
    assign mouse_port_data_out     = 1'b0;
    assign mouse_port_data_oe      = data_oe[1];

    assign kbd_tx_ready  = tx_rdy[0];
    assign kbd_rx_byte   = rx_byte[7:0];
    assign kbd_rx_valid  = rx_vld[0];
    assign kbd_rx_err    = rx_bad[0];
    assign kbd_clk_fault = clk_bad[0];
    assign mouse_rx_err    = rx_bad[1];
    assign mouse_clk_fault = clk_bad[1];

    // mouse bytes gather into three-byte packets; a bad word restarts the packet
    reg [1:0]  mcnt_r;
    reg [15:0] mhold_r;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mcnt_r             <= 2'h0;
            mhold_r            <= 16'h0000;
            mouse_packet       <= 24'h000000;
            mouse_packet_valid <= 1'b0;
        end else begin
            mouse_packet_valid <= 1'b0;
            if (rx_vld[1]) begin
                if (rx_bad[1]) begin
                    mcnt_r <= 2'h0;
                end else if (mcnt_r == `PS2H_PKT_BYTES - 2'h1) begin
                    mouse_packet       <= {rx_byte[15:8], mhold_r};
                    mouse_packet_valid <= 1'b1;
                    mcnt_r             <= 2'h0;
                end else begin
                    mhold_r <= {rx_byte[15:8], mhold_r[15:8]};
                    mcnt_r  <= mcnt_r + 2'h1;
                end
            end
        end
    end

endmodule

// ==== tb/ps2h_dev.sv ====
// peripheral model of one ps/2 port: sends words, catches host words
// assumes lclk and ldat are resolved wire levels with pull-ups
module ps2h_dev (
    input  wire logic lclk,
    input  wire logic ldat,
    output logic      pull
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        busy = 1'b0;
    logic [10:0] sr = 11'h000;
    logic [10:0] got = 11'h000;
    int          cnt = 0;
    int          gotn = 0;
    initial pull = 1'b0;
    // clock is never touched: the host alone paces the link
    task automatic send(input logic [10:0] f);
        busy = 1'b1;
        for (int i = 0; i < 11; i++) begin
            @(negedge lclk);
            pull <= ~f[i];
        end
        @(negedge lclk);
        pull <= 1'b0;
        busy = 1'b0;
    endtask
    always @(posedge lclk) begin
        if (!busy && (cnt != 0 || !ldat)) begin
            sr = {ldat, sr[10:1]};
            cnt = (cnt == 10) ? 0 : cnt + 1;
            if (cnt == 0) begin
                got = sr;
                gotn++;
            end
        end
    end
endmodule

// ==== tb/ps2h_port_props.sv ====
// checker of ps2h_port: pin timing of both ports
// assumes binding into ps2h_port; rst_b active low
module ps2h_port_props (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic keyboard_port_clock_oe,
    input wire logic keyboard_port_clock_out,
    input wire logic keyboard_port_data_oe,
    input wire logic keyboard_port_data_out,
    input wire logic mouse_port_clock_oe,
    input wire logic mouse_port_data_oe,
    input wire logic kbd_tx_valid,
    input wire logic kbd_tx_ready,
    input wire logic kbd_rx_valid,
    input wire logic kbd_rx_err,
    input wire logic mouse_packet_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    chk_low_only: assert property (!keyboard_port_clock_out && !keyboard_port_data_out)
        else $error("pin driven high");
    chk_clk_phase: assert property ($rose(keyboard_port_clock_oe) |->
        keyboard_port_clock_oe [*8] ##1 !keyboard_port_clock_oe)
        else $error("clock low phase length");
    chk_same_clk: assert property (keyboard_port_clock_oe == mouse_port_clock_oe)
        else $error("port clocks differ");
    chk_mouse_quiet: assert property (!mouse_port_data_oe)
        else $error("mouse data pulled");
    chk_tx_take: assert property (kbd_tx_valid && kbd_tx_ready |=>
        keyboard_port_data_oe && keyboard_port_clock_oe)
        else $error("start bit missing");
    chk_ready_tick: assert property (kbd_tx_ready |->
        !keyboard_port_clock_oe && !keyboard_port_data_oe ##1 keyboard_port_clock_oe)
        else $error("ready off tick");
    chk_data_edge: assert property ($changed(keyboard_port_data_oe) |->
        $rose(keyboard_port_clock_oe))
        else $error("data moved off fall");
    chk_err_valid: assert property (kbd_rx_err |-> kbd_rx_valid)
        else $error("error without word");
    chk_rx_gap: assert property (kbd_rx_valid |=> !kbd_rx_valid [*8])
        else $error("words too close");
    chk_pkt_pulse: assert property (mouse_packet_valid |=> !mouse_packet_valid)
        else $error("packet pulse long");
endmodule

bind ps2h_port ps2h_port_props u_props (
    .mclk(mclk), .rst_b(rst_b), .keyboard_port_clock_oe(keyboard_port_clock_oe),
    .keyboard_port_clock_out(keyboard_port_clock_out),
    .keyboard_port_data_oe(keyboard_port_data_oe),
    .keyboard_port_data_out(keyboard_port_data_out),
    .mouse_port_clock_oe(mouse_port_clock_oe), .mouse_port_data_oe(mouse_port_data_oe),
    .kbd_tx_valid(kbd_tx_valid), .kbd_tx_ready(kbd_tx_ready), .kbd_rx_valid(kbd_rx_valid),
    .kbd_rx_err(kbd_rx_err), .mouse_packet_valid(mouse_packet_valid));

// ==== tb/ps2h_port_tb.sv ====
// testbench of ps2h_port: queue reference model against both ports
// assumes ps2h_dev on each port and the bound checker
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module ps2h_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  kbd_tx_byte = 8'h00;
    logic        kbd_tx_valid = 1'b0;
    logic        kco, kcoe, kdo, kdoe, mco, mcoe, mdo, mdoe, kpull, mpull;
    logic        kready, kv, ke, mv, me;
    logic [7:0]  kbyte;
    logic [23:0] mpkt;
    logic [23:0] macc;
    logic        kcpull = 1'b0;
    logic        kfl, mfl;
    logic [8:0]  kexp;
    logic [23:0] mexp;
    int          kfault = 0, mfault = 0;
    logic [8:0]  kq[$];
    logic [23:0] mq[$];
    int          mn = 0, merr = 0, mseen = 0, err_count = 0, n_checks = 0, cyc = 0;
    wire         kck_w = (kcoe ? kco : 1'b1) & !kcpull;
    wire         kdat_w = (kdoe ? kdo : 1'b1) & !kpull;
    wire         mck_w = mcoe ? mco : 1'b1;
    wire         mdat_w = (mdoe ? mdo : 1'b1) & !mpull;
    ps2h_port dut (.mclk(mclk), .rst_b(rst_b),
        .keyboard_port_clock_in(kck_w), .keyboard_port_clock_out(kco),
        .keyboard_port_clock_oe(kcoe), .keyboard_port_data_in(kdat_w),
        .keyboard_port_data_out(kdo), .keyboard_port_data_oe(kdoe),
        .mouse_port_clock_in(mck_w), .mouse_port_clock_out(mco), .mouse_port_clock_oe(mcoe),
        .mouse_port_data_in(mdat_w), .mouse_port_data_out(mdo), .mouse_port_data_oe(mdoe),
        .kbd_tx_byte(kbd_tx_byte), .kbd_tx_valid(kbd_tx_valid), .kbd_tx_ready(kready),
        .kbd_rx_byte(kbyte), .kbd_rx_valid(kv), .kbd_rx_err(ke), .kbd_clk_fault(kfl),
        .mouse_packet(mpkt), .mouse_packet_valid(mv), .mouse_rx_err(me),
        .mouse_clk_fault(mfl));
    ps2h_dev kdev (.lclk(kck_w), .ldat(kdat_w), .pull(kpull));
    ps2h_dev mdev (.lclk(mck_w), .ldat(mdat_w), .pull(mpull));
    always #4 mclk = ~mclk;
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // bad[0] flips parity, bad[1] clears the stop bit
    task automatic word(input bit mse, input logic [7:0] b, input logic [1:0] bad);
        logic [10:0] f;
        f = {~bad[1], ~^b ^ bad[0], b, 1'b0};
        if (!mse) begin
            kq.push_back({|bad, b});
            kdev.send(f);
        end else begin
            if (|bad) begin
                mn = 0;
                merr++;
            end else begin
                macc[mn*8 +: 8] = b;
                mn++;
            end
            if (mn == 3) begin
                mq.push_back(macc);
                mn = 0;
            end
            mdev.send(f);
        end
    endtask
    task automatic host_tx(input logic [7:0] b);
        int n;
        n = kdev.gotn;
        kbd_tx_byte <= b;
        kbd_tx_valid <= 1'b1;
        do @(posedge mclk); while (kready !== 1'b1);
        kbd_tx_valid <= 1'b0;
        repeat (200) @(posedge mclk);
        `CHK(kdev.gotn, n + 1)
        `CHK(kdev.got, {1'b1, ~^b, b, 1'b0})
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            print_verdict();
        end
        // pop once: the macro repeats its expected argument in the message
        if (kv === 1'b1) begin
            kexp = kq.size() ? kq.pop_front() : 9'bx;
            `CHK({ke, kbyte}, kexp)
        end
        if (me === 1'b1) mseen++;
        if (kfl !== 1'b0) kfault++;
        if (mfl !== 1'b0) mfault++;
        if (mv === 1'b1) begin
            mexp = mq.size() ? mq.pop_front() : 24'bx;
            `CHK(mpkt, mexp)
        end
    end
    initial begin
        void'($urandom(32'hda0518bc));
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (20) @(posedge mclk);
        fork
            for (int i = 0; i < 6; i++)
                word(0, i == 0 ? 8'hFF : 8'($urandom), (i < 4) ? 2'b00 : 2'(i - 3));
            for (int i = 0; i < 8; i++)
                word(1, 8'($urandom), (i == 4) ? 2'b01 : 2'b00);
        join
        @(posedge mclk);
        host_tx(8'h00);
        for (int i = 0; i < 2; i++)
            host_tx(8'($urandom));
        repeat (50) @(posedge mclk);
        `CHK(mseen, merr)
        `CHK(kq.size() + mq.size(), 0)
        `CHK(kfault + mfault, 0)
        // a foreign pull on the keyboard clock must show as a fault
        kcpull <= 1'b1;
        repeat (20) @(posedge mclk);
        kcpull <= 1'b0;
        repeat (4) @(posedge mclk);
        `CHK(kfault != 0, 1'b1)
        `CHK(mfault, 0)
        print_verdict();
    end
endmodule
